// file: design/fwsr_pkg.sv
// Shared constants for the flash status-reporting host controller.
// Assumes a 250 MHz ref_clk and a byte-wide asynchronous flash outside.
package fwsr_pkg;

    // ------------------------------------------------------------
    // Clock and flash timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_ACC_NS = 55;
    localparam int T_WP_NS = 30;
    localparam int T_WPH_NS = 20;
    localparam int T_DF_NS = 18;
    localparam int SYNC_STAGES = 2;
    // Least times round up to whole cycles
    localparam logic [4:0] ACC_CYC =
        5'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
    localparam logic [4:0] WP_CYC =
        5'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] WPH_CYC =
        5'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] DF_CYC =
        5'((T_DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Flash status bits and commands
    // ------------------------------------------------------------
    localparam int COMPLETION_POLL_POS = 7;
    localparam int ANY_ADDRESS_TOGGLE_POS = 6;
    localparam int TIME_LIMIT_FAIL_POS = 5;
    localparam int ERASE_WINDOW_POS = 3;
    localparam int SECTOR_TOGGLE_POS = 2;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;

    // ------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h1C;
    localparam logic [16:0] ADDR_RESET = 17'h0_0000;
    localparam logic [7:0] WDATA_RESET = 8'h00;
    localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

    // CTRL operation codes, bits [2:0]; bit 3 aborts a poll
    localparam logic [2:0] OP_TOGGLE_POLL = 3'h1;
    localparam logic [2:0] OP_RESET_CMD = 3'h2;
    localparam logic [2:0] OP_ADD_SECTOR = 3'h3;
    localparam logic [2:0] OP_RAW_READ = 3'h4;
    localparam logic [2:0] OP_RAW_WRITE = 3'h5;
    localparam int CTRL_ABORT_POS = 3;

    // Result codes in STATUS[3:1]
    typedef enum logic [2:0] {
        RES_NONE = 3'b000,
        RES_OK = 3'b001,
        RES_FAILED = 3'b010,
        RES_WINDOW_CLOSED = 3'b011,
        RES_NOT_ACCEPTED = 3'b100,
        RES_ABORTED = 3'b101
    } fwsr_result_t;

    // Interrupt event positions
    localparam int EV_OK = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_ERASE = 2;
endpackage

// file: design/fwsr_bus_cycle.sv
// One asynchronous read or write cycle on the flash pins.
// Assumes the flash data pins are asynchronous to ref_clk.
`timescale 1ns/1ps
module fwsr_bus_cycle (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Cycle request
    input wire logic start,
    input wire logic is_write,
    input wire logic [16:0] addr,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata,
    // Flash pins
    output logic [16:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe
);
    import fwsr_pkg::*;

    typedef enum logic [2:0] {
        B_IDLE = 3'b000,
        B_READ = 3'b001,
        B_WR_LOW = 3'b010,
        B_WR_HIGH = 3'b011,
        B_RECOVER = 3'b100
    } fwsr_bus_state_t;

    fwsr_bus_state_t state;
    fwsr_bus_state_t next_state;
    logic [4:0] count;
    logic [7:0] dq_meta;
    logic [7:0] dq_sync;
    wire logic count_done = (count == 5'h0_0001);
    wire logic [4:0] next_count_load;

    // ------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            B_IDLE: if (start) next_state = is_write ? B_WR_LOW : B_READ;
            B_READ: if (count_done) next_state = B_RECOVER;
            B_WR_LOW: if (count_done) next_state = B_WR_HIGH;
            B_WR_HIGH: if (count_done) next_state = B_IDLE;
            B_RECOVER: if (count_done) next_state = B_IDLE;
            default: next_state = B_IDLE;
        endcase
    end

    assign next_count_load =
        (next_state == B_READ) ? ACC_CYC :
        (next_state == B_WR_LOW) ? WP_CYC :
        (next_state == B_WR_HIGH) ? WPH_CYC : DF_CYC;

    // Done in the last recovery or write-high cycle, so cycles can follow at once
    assign done = count_done &&
        (state == B_WR_HIGH || state == B_RECOVER);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= B_IDLE;
            count <= 5'h0_0000;
        end else begin
            state <= next_state;
            if (next_state != state)
                count <= next_count_load;
            else if (count != 5'h0_0000)
                count <= count - 5'h0_0001;
        end
    end

    // ------------------------------------------------------------
    // Pins; address and data held through the whole cycle
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flash_addr <= 17'h0_0000;
            dq_out <= 8'h00;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            dq_oe <= 1'b0;
        end else begin
            if (state == B_IDLE && start) begin
                flash_addr <= addr;
                dq_out <= wdata;
            end
            flash_ce_n <= !(next_state == B_READ ||
                next_state == B_WR_LOW || next_state == B_WR_HIGH);
            flash_oe_n <= (next_state != B_READ);
            flash_we_n <= (next_state != B_WR_LOW);
            dq_oe <= (next_state == B_WR_LOW || next_state == B_WR_HIGH);
        end
    end

    // Two flops ahead of the capture; the access count covers them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dq_meta <= 8'h00;
            dq_sync <= 8'h00;
            rdata <= 8'h00;
        end else begin
            dq_meta <= dq_in;
            dq_sync <= dq_meta;
            if (state == B_READ && count_done)
                rdata <= dq_sync;
        end
    end
endmodule // fwsr_bus_cycle

// file: design/fwsr_host.sv
// Host controller that runs status checks on an asynchronous flash.
// Assumes software on APB and the flash wired to the pin group below.
//
// Operation
// - Read status twice in a row and compare toggle bit first.
// - Toggling with fail bit high: retest; still toggling means fail, reset.
// - Toggling without fail: keep polling, or restart from two reads.
// - After a time-limit failure, write the reset command.
// - Window bit may be skipped only with adds under 50 us apart.
// - Check window bit before and after every added sector erase.
// - Status reads use program address or an erasing sector address.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module fwsr_host (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Flash pins
    output logic [16:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe
);
    import fwsr_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_TG_FIRST = 4'b0001,
        S_TG_NEXT = 4'b0010,
        S_TG_RECHK = 4'b0011,
        S_FINAL_RD = 4'b0100,
        S_RESET_WR = 4'b0101,
        S_ER_PRE = 4'b0110,
        S_ER_WR = 4'b0111,
        S_ER_POST = 4'b1000,
        S_RAW_RD = 4'b1001,
        S_RAW_WR = 4'b1010
    } fwsr_state_t;

    fwsr_state_t state;
    fwsr_state_t next_state;
    fwsr_result_t result;
    fwsr_result_t next_result;
    logic [16:0] op_addr;
    logic [7:0] op_wdata;
    logic [7:0] rd_data;
    logic prev_toggle;
    logic next_prev_toggle;
    logic abort_req;
    logic issued;
    logic finish;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    logic [2:0] events;
    logic cyc_done;
    logic [7:0] cyc_rdata;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic setup = psel && !penable;
    wire logic wr_access = psel && penable && pwrite;
    wire logic known = paddr == REG_CTRL || paddr == REG_ADDR ||
        paddr == REG_WDATA || paddr == REG_RDATA ||
        paddr == REG_STATUS || paddr == REG_IRQ_STATUS ||
        paddr == REG_IRQ_ENABLE || paddr == REG_IRQ_CLEAR;
    wire logic wr_ctrl = wr_access && paddr == REG_CTRL;
    wire logic busy = (state != S_IDLE);
    wire logic [2:0] op_code = pwdata[2:0];
    wire logic start_op = wr_ctrl && !busy;
    wire logic abort_now = wr_ctrl && pwdata[CTRL_ABORT_POS];
    wire logic [31:0] rd_mux =
        (paddr == REG_ADDR) ? {15'h0000, op_addr} :
        (paddr == REG_WDATA) ? {24'h00_0000, op_wdata} :
        (paddr == REG_RDATA) ? {24'h00_0000, rd_data} :
        (paddr == REG_STATUS) ? {28'h000_0000, result, busy} :
        (paddr == REG_IRQ_STATUS) ? {29'h0000_0000, irq_status} :
        (paddr == REG_IRQ_ENABLE) ? {29'h0000_0000, irq_enable} :
        32'h0000_0000;

    // Zero wait states; read data is caught in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !known;
    assign irq = |(irq_status & irq_enable);

    // ------------------------------------------------------------
    // Flash cycle engine
    // ------------------------------------------------------------
    wire logic cyc_state = state != S_IDLE;
    wire logic cyc_write =
        state == S_RESET_WR || state == S_ER_WR || state == S_RAW_WR;
    wire logic [7:0] cyc_wdata =
        (state == S_RESET_WR) ? CMD_RESET :
        (state == S_ER_WR) ? CMD_SECTOR_ERASE : op_wdata;
    wire logic cyc_start = cyc_state && !issued;
    wire logic rd_toggle = cyc_rdata[ANY_ADDRESS_TOGGLE_POS];
    wire logic rd_fail = cyc_rdata[TIME_LIMIT_FAIL_POS];
    wire logic rd_window = cyc_rdata[ERASE_WINDOW_POS];

    // Status reads go to the software address, a valid one
    fwsr_bus_cycle u_cycle (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(op_addr),
        .wdata(cyc_wdata),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .flash_addr(flash_addr),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n),
        .dq_in(dq_in),
        .dq_out(dq_out),
        .dq_oe(dq_oe)
    );

    // ------------------------------------------------------------
    // Operation sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_result = result;
        next_prev_toggle = prev_toggle;
        finish = 1'b0;
        case (state)
            S_IDLE: begin
                if (start_op) begin
                    case (op_code)
                        OP_TOGGLE_POLL: next_state = S_TG_FIRST;
                        OP_RESET_CMD: next_state = S_RESET_WR;
                        OP_ADD_SECTOR: next_state = S_ER_PRE;
                        OP_RAW_READ: next_state = S_RAW_RD;
                        OP_RAW_WRITE: next_state = S_RAW_WR;
                        default: next_state = S_IDLE;
                    endcase
                end
            end
            S_TG_FIRST: if (cyc_done) begin
                next_prev_toggle = rd_toggle;
                next_state = S_TG_NEXT;
            end
            S_TG_NEXT: if (cyc_done) begin
                next_prev_toggle = rd_toggle;
                if (rd_toggle == prev_toggle) begin
                    next_state = S_FINAL_RD;
                end else if (rd_fail) begin
                    next_state = S_TG_RECHK;
                end else if (abort_req) begin
                    // Leaving drops history; next start reads twice again
                    next_result = RES_ABORTED;
                    finish = 1'b1;
                    next_state = S_IDLE;
                end
            end
            S_TG_RECHK: if (cyc_done) begin
                if (rd_toggle == prev_toggle) begin
                    next_state = S_FINAL_RD;
                end else begin
                    next_result = RES_FAILED;
                    next_state = S_RESET_WR;
                end
            end
            S_FINAL_RD: if (cyc_done) begin
                next_result = RES_OK;
                finish = 1'b1;
                next_state = S_IDLE;
            end
            S_RESET_WR: if (cyc_done) begin
                if (result != RES_FAILED)
                    next_result = RES_OK;
                finish = 1'b1;
                next_state = S_IDLE;
            end
            S_ER_PRE: if (cyc_done) begin
                if (rd_window) begin
                    // Closed window: the add would be ignored
                    next_result = RES_WINDOW_CLOSED;
                    finish = 1'b1;
                    next_state = S_IDLE;
                end else begin
                    next_state = S_ER_WR;
                end
            end
            S_ER_WR: if (cyc_done) next_state = S_ER_POST;
            S_ER_POST: if (cyc_done) begin
                // Always checked, never relying on add spacing
                next_result = rd_window ? RES_NOT_ACCEPTED : RES_OK;
                finish = 1'b1;
                next_state = S_IDLE;
            end
            S_RAW_RD, S_RAW_WR: if (cyc_done) begin
                next_result = RES_OK;
                finish = 1'b1;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    assign events[EV_OK] = finish && next_result == RES_OK;
    assign events[EV_FAIL] = finish &&
        (next_result == RES_FAILED || next_result == RES_ABORTED);
    assign events[EV_ERASE] = finish &&
        (next_result == RES_WINDOW_CLOSED ||
        next_result == RES_NOT_ACCEPTED);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= S_IDLE;
            result <= RES_NONE;
            prev_toggle <= 1'b0;
            issued <= 1'b0;
        end else begin
            state <= next_state;
            result <= start_op ? RES_NONE : next_result;
            prev_toggle <= next_prev_toggle;
            issued <= cyc_start ? 1'b1 : (cyc_done ? 1'b0 : issued);
        end
    end

    // Abort is sticky until the poll loop sees it or the host goes idle
    always_ff @(posedge ref_clk) begin
        if (reset)
            abort_req <= 1'b0;
        else if (abort_now && busy)
            abort_req <= 1'b1;
        else if (!busy)
            abort_req <= 1'b0;
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            op_addr <= ADDR_RESET;
            op_wdata <= WDATA_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
            rd_data <= 8'h00;
            prdata <= 32'h0000_0000;
        end else begin
            if (wr_access && paddr == REG_ADDR && !busy)
                op_addr <= pwdata[16:0];
            if (wr_access && paddr == REG_WDATA && !busy)
                op_wdata <= pwdata[7:0];
            if (wr_access && paddr == REG_IRQ_ENABLE)
                irq_enable <= pwdata[2:0];
            if (cyc_done && !cyc_write)
                rd_data <= cyc_rdata;
            if (setup)
                prdata <= rd_mux;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset)
            irq_status <= 3'h0;
        else if (wr_access && paddr == REG_IRQ_CLEAR)
            irq_status <= (irq_status & ~pwdata[2:0]) | events;
        else
            irq_status <= irq_status | events;
    end
endmodule // fwsr_host

// file: bench/fwsr_host_monitor.sv
// Concurrent checks on the host's APB and flash pins.
// Assumes binding to fwsr_host; sees only its ports.
`timescale 1ns/1ps
module fwsr_host_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Flash pins
    input wire logic [16:0] flash_addr,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h1C
        |-> pslverr) else $error("unmapped access without pslverr");
    a_read_strobes: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
        else $error("output enable without chip enable");
    a_read_width: assert property ($fell(flash_oe_n) |->
        (!flash_oe_n)[*8] ##1 (!flash_oe_n)[*8] ##1 flash_oe_n)
        else $error("read strobe width wrong");
    a_read_gap: assert property ($rose(flash_oe_n) |->
        (flash_oe_n && flash_we_n)[*5]) else $error("read recovery short");
    a_addr_held: assert property (
        !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
        else $error("flash address moved within cycle");
    a_write_width: assert property ($fell(flash_we_n) |->
        (!flash_we_n)[*8] ##1 (flash_we_n && !flash_ce_n)[*5])
        else $error("write pulse shape wrong");
    a_write_data: assert property (!flash_we_n && !$past(flash_we_n)
        |-> dq_oe && $stable(dq_out)) else $error("write data not held");
    a_drive_safe: assert property (dq_oe |-> flash_oe_n && !flash_ce_n)
        else $error("data driven outside a write");

    c_reset_cmd: cover property ($fell(flash_we_n) && dq_out == 8'hF0);
    c_sector_add: cover property ($fell(flash_we_n) && dq_out == 8'h30);
    c_unmapped: cover property (psel && penable && pslverr);
endmodule // fwsr_host_monitor

bind fwsr_host fwsr_host_monitor i_fwsr_host_monitor (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .dq_out(dq_out),
    .dq_oe(dq_oe)
);

// file: bench/fwsr_flash_model.sv
// Behavioural flash answering status reads and command writes.
// Assumes reads framed by chip and output enable, writes by write enable.
`timescale 1ns/1ps
module fwsr_flash_model #(
    parameter longint WIN_NS = 1600,
    parameter logic [7:0] ARRAY_BYTE = 8'hC3
) (
    // Flash pins
    input wire logic [16:0] flash_addr,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    output logic [7:0] dq_in
);
    int run_left = 0;
    int fail_at = -1;
    int reads = 0;
    int resets = 0;
    int adds = 0;
    longint win_end = 0;
    logic erasing = 1'b0;
    logic flip_any = 1'b0;
    logic flip_sector = 1'b0;
    logic suspended = 1'b0;
    logic [7:0] rd_q = 8'h00;
    logic [16:0] last_addr = 17'h0_0000;
    logic [7:0] last_data = 8'h00;
    wire rd_n = flash_ce_n | flash_oe_n;

    // Run of -1 toggles until a reset command arrives
    task automatic start_op(input int run, input int fail);
        run_left = run;
        fail_at = fail;
        reads = 0;
        erasing = 1'b0;
        suspended = 1'b0;
    endtask

    // Short windows let an add land after the time-out
    task automatic open_window(input longint len);
        start_op(-1, -1);
        erasing = 1'b1;
        win_end = $time + len;
    endtask

    // Suspended sector: poll bit 1, any-address toggle frozen
    task automatic suspend();
        start_op(-1, -1);
        erasing = 1'b1;
        suspended = 1'b1;
    endtask

    always @(negedge rd_n) begin
        if (run_left != 0) begin
            if (!suspended) flip_any = ~flip_any;
            if (erasing) flip_sector = ~flip_sector;
            reads++;
            rd_q[7] = suspended;
            rd_q[6] = flip_any;
            rd_q[5] = fail_at >= 0 && reads > fail_at;
            rd_q[4] = 1'b0;
            rd_q[3] = erasing && $time >= win_end;
            rd_q[2] = flip_sector;
            rd_q[1:0] = 2'b00;
            if (run_left > 0) run_left--;
        end else begin
            rd_q = ARRAY_BYTE;
        end
    end

    always @(posedge flash_we_n) begin
        if (flash_ce_n === 1'b0) begin
            last_addr = flash_addr;
            last_data = dq_out;
            if (dq_out == 8'hF0) begin
                start_op(0, -1);
                resets++;
            end else if (dq_out == 8'h30 && erasing && $time < win_end) begin
                win_end = $time + WIN_NS;
                adds++;
            end
        end
    end

    // Released bus shows the inverse, so a stale byte never passes
    assign dq_in = dq_oe ? dq_out : (rd_n ? ~rd_q : rd_q);
endmodule // fwsr_flash_model

// file: bench/fwsr_host_bench.sv
// Self-checking bench for the flash status host controller.
// Assumes the flash model beside it and the bound pin checker.
`timescale 1ns/1ps
module fwsr_host_bench;
    import fwsr_pkg::*;
    localparam int WIN_NS = 1600;
    localparam logic [7:0] ARRAY = 8'hC3;
    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, dq_in, dq_out;
    logic [31:0] pwdata, prdata, sq;
    logic [16:0] flash_addr;
    logic flash_ce_n, flash_oe_n, flash_we_n, dq_oe, last_err;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    fwsr_host i_fwsr_host (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe)
    );
    fwsr_flash_model #(.WIN_NS(WIN_NS), .ARRAY_BYTE(ARRAY))
        i_fwsr_flash_model (
        .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    task automatic cmp(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input string nm);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        cmp(nm, exp, q);
    endtask

    // Starts an operation and waits for busy to drop
    task automatic run(input logic [3:0] op, input fwsr_result_t res);
        logic [31:0] q;
        int n;
        n = 0;
        wr(REG_CTRL, {28'h0, op});
        do begin
            apb(1'b0, REG_STATUS, 32'h0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 400);
        cmp("result", {28'h0, res, 1'b0}, q);
    endtask

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(REG_ADDR, 32'h0, "addr reset");
        rd(REG_WDATA, 32'h0, "wdata reset");
        rd(REG_IRQ_ENABLE, 32'h0, "enable reset");
        rd(REG_STATUS, 32'h0, "status reset");
        rd(8'h20, 32'h0, "unmapped data");
        cmp("unmapped err", 32'h1, {31'h0, last_err});
        wr(REG_IRQ_ENABLE, 32'h7);
        i_fwsr_flash_model.start_op(3, -1);
        run({1'b0, OP_TOGGLE_POLL}, RES_OK);
        rd(REG_RDATA, {24'h0, ARRAY}, "array byte");
        cmp("irq ok", 32'h1, {31'h0, irq});
        rd(REG_IRQ_STATUS, 32'h1, "ok event");
        wr(REG_IRQ_CLEAR, 32'h7);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        i_fwsr_flash_model.start_op(-1, 2);
        run({1'b0, OP_TOGGLE_POLL}, RES_FAILED);
        cmp("reset sent", 32'h1, i_fwsr_flash_model.resets);
        rd(REG_IRQ_STATUS, 32'h2, "fail event");
        wr(REG_IRQ_CLEAR, 32'h7);
        wr(REG_IRQ_ENABLE, 32'h0);
        i_fwsr_flash_model.start_op(-1, -1);
        wr(REG_CTRL, {29'h0, OP_TOGGLE_POLL});
        repeat (120) @(posedge ref_clk);
        run(4'h8, RES_ABORTED);
        cmp("irq masked", 32'h0, {31'h0, irq});
        rd(REG_IRQ_STATUS, 32'h2, "abort event");
        wr(REG_IRQ_CLEAR, 32'h7);
        wr(REG_IRQ_ENABLE, 32'h7);
        i_fwsr_flash_model.open_window(WIN_NS);
        run({1'b0, OP_ADD_SECTOR}, RES_OK);
        cmp("sector added", 32'h1, i_fwsr_flash_model.adds);
        wr(REG_IRQ_CLEAR, 32'h7);
        repeat (WIN_NS / 4 + 20) @(posedge ref_clk);
        run({1'b0, OP_ADD_SECTOR}, RES_WINDOW_CLOSED);
        cmp("closed add", 32'h1, i_fwsr_flash_model.adds);
        rd(REG_IRQ_STATUS, 32'h4, "erase event");
        wr(REG_IRQ_CLEAR, 32'h7);
        // Window closes between the pre-check and the add
        i_fwsr_flash_model.open_window(60);
        run({1'b0, OP_ADD_SECTOR}, RES_NOT_ACCEPTED);
        cmp("late add", 32'h1, i_fwsr_flash_model.adds);
        rd(REG_IRQ_STATUS, 32'h4, "late event");
        i_fwsr_flash_model.suspend();
        run({1'b0, OP_TOGGLE_POLL}, RES_OK);
        apb(1'b0, REG_RDATA, 32'h0, sq);
        cmp("suspend poll bit", 32'h1, {31'h0, sq[7]});
        run({1'b0, OP_RESET_CMD}, RES_OK);
        cmp("reset cmd", 32'h2, i_fwsr_flash_model.resets);
        wr(REG_ADDR, 32'h0001_2345);
        wr(REG_WDATA, 32'h5A);
        run({1'b0, OP_RAW_WRITE}, RES_OK);
        cmp("raw addr", 32'h0001_2345, {15'h0, i_fwsr_flash_model.last_addr});
        cmp("raw data", 32'h5A, {24'h0, i_fwsr_flash_model.last_data});
        run({1'b0, OP_RAW_READ}, RES_OK);
        rd(REG_RDATA, {24'h0, ARRAY}, "raw read");
        close_out();
    end
endmodule // fwsr_host_bench
